// ### crms_pkg.sv
// crms_pkg: constants and types shared by the cpu register block.
// assumes a single 200 MHz clock domain and a synchronous active-high reset.
package crms_pkg;

  // ==========================================================================
  // widths
  localparam int unsigned XLEN      = 32;
  localparam int unsigned PC_BITS   = 24;
  localparam int unsigned STAT_BITS = 8;
  localparam int unsigned CODE_BITS = 16;
  localparam int unsigned RIDX_BITS = 5;
  localparam int unsigned NUM_GPR   = 32;

  // ==========================================================================
  // system register numbers
  localparam logic [4:0] SR_IRQ_SAVED_PC     = 5'h00;
  localparam logic [4:0] SR_IRQ_SAVED_STATUS = 5'h01;
  localparam logic [4:0] SR_NMI_SAVED_PC     = 5'h02;
  localparam logic [4:0] SR_NMI_SAVED_STATUS = 5'h03;
  localparam logic [4:0] SR_EXCEPTION_CAUSE  = 5'h04;
  localparam logic [4:0] SR_STATUS_WORD      = 5'h05;
  localparam logic [4:0] SR_LAST_DEFINED     = 5'h05;

  // ==========================================================================
  // status word fields and reset value
  localparam int unsigned ST_NMI_IN_PROGRESS   = 7;
  localparam int unsigned ST_TRAP_IN_PROGRESS  = 6;
  localparam int unsigned ST_INTERRUPT_DISABLE = 5;
  localparam int unsigned ST_STICKY_CLAMP      = 4;
  localparam int unsigned ST_CARRY             = 3;
  localparam int unsigned ST_SIGNED_RANGE_EXC  = 2;
  localparam int unsigned ST_NEGATIVE          = 1;
  localparam int unsigned ST_ZERO              = 0;
  localparam logic [7:0]  STATUS_RESET         = 8'h20;

  // exception cause fields
  localparam int unsigned CAUSE_NMI_LSB = 16;
  localparam int unsigned CAUSE_TRP_LSB = 0;

  // ==========================================================================
  // reset entry points (internal program memory and external memory)
  localparam logic [23:0] RESET_ENTRY_INTERNAL = 24'h000000;
  localparam logic [23:0] RESET_ENTRY_EXTERNAL = 24'h000000;

  // ==========================================================================
  // operating modes
  typedef enum logic [2:0] {
    CRMS_ROMLESS,
    CRMS_RESERVED,
    CRMS_SINGLE_CHIP,
    CRMS_PROM_READ,
    CRMS_PROM_PROGRAM
  } crms_mode_e;

endpackage

// ### crms_gpr.sv
// crms_gpr: thirty-two general registers, two registered read ports, one write port.
// assumes read and write addresses come from logic on the same clock.
`timescale 1ns/1ps
module crms_gpr (
  input  wire logic                          i_clk,
  input  wire logic                          i_srst,
  input  wire logic [crms_pkg::RIDX_BITS-1:0] i_rd_addr_a,
  input  wire logic [crms_pkg::RIDX_BITS-1:0] i_rd_addr_b,
  output logic      [crms_pkg::XLEN-1:0]      o_rd_data_a,
  output logic      [crms_pkg::XLEN-1:0]      o_rd_data_b,
  input  wire logic                          i_we,
  input  wire logic [crms_pkg::RIDX_BITS-1:0] i_waddr,
  input  wire logic [crms_pkg::XLEN-1:0]      i_wdata
);
  import crms_pkg::*;

  // ==========================================================================
  // storage; entry zero is never written and always reads zero
  logic [XLEN-1:0] regs_r [NUM_GPR];

  genvar g;
  generate
    for (g = 0; g < NUM_GPR; g++) begin : g_reg
      always_ff @(posedge i_clk) begin
        if (i_srst || g == 0) begin
          regs_r[g] <= '0;
        end else if (i_we && i_waddr == RIDX_BITS'(g)) begin
          regs_r[g] <= i_wdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_rd_data_a <= '0;
      o_rd_data_b <= '0;
    end else begin
      o_rd_data_a <= regs_r[i_rd_addr_a];
      o_rd_data_b <= regs_r[i_rd_addr_b];
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  a_zero_reg_read: assert property (
    i_rd_addr_a == '0 |=> o_rd_data_a == '0)
    else $error("register zero read non-zero");

  a_write_read_back: assert property (
    i_we && i_waddr != '0 ##1 i_rd_addr_a == $past(i_waddr) && !(i_we && i_waddr == i_rd_addr_a)
    |=> o_rd_data_a == $past(i_wdata, 2))
    else $error("general register lost a write");

endmodule

// ### crms_mode_sel.sv
// crms_mode_sel: synchronises the strap pins and latches the operating mode at reset.
// assumes the straps are held stable while the part runs.
`timescale 1ns/1ps
module crms_mode_sel (
  input  wire logic                 i_clk,
  input  wire logic                 i_srst,
  input  wire logic                 i_mode_select_pin_low,
  input  wire logic                 i_mode_select_pin_high,
  input  wire logic                 i_prog_voltage_high,
  output crms_pkg::crms_mode_e      o_mode
);
  import crms_pkg::*;

  // ==========================================================================
  // two-stage synchronisers for the three pins
  logic [2:0] pins_meta_r;
  logic [2:0] pins_sync_r;
  crms_mode_e mode_nxt;

  always_ff @(posedge i_clk) begin
    pins_meta_r <= {i_prog_voltage_high, i_mode_select_pin_high, i_mode_select_pin_low};
    pins_sync_r <= pins_meta_r;
  end

  // ==========================================================================
  // decode
  always_comb begin
    case (pins_sync_r)
      3'h0, 3'h4: mode_nxt = CRMS_ROMLESS;
      3'h2, 3'h6: mode_nxt = CRMS_SINGLE_CHIP;
      3'h3:       mode_nxt = CRMS_PROM_READ;
      3'h7:       mode_nxt = CRMS_PROM_PROGRAM;
      default:    mode_nxt = CRMS_RESERVED;
    endcase
  end

  // sampled throughout reset, frozen from release until the next reset
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_mode <= mode_nxt;
    end
  end

  // ==========================================================================
  // checks
  a_mode_frozen: assert property (@(posedge i_clk)
    !i_srst && !$past(i_srst) |-> $stable(o_mode))
    else $error("mode changed outside reset");

endmodule

// ### crms_regs.sv
// crms_regs: cpu register set with system registers, status word and mode selection.
// assumes execution and exception logic on the same clock drive every request input.
`timescale 1ns/1ps

// Notes on behaviour
// - thirty-two general registers; register zero always reads zero
// - program counter keeps 24 bits; upper byte zero; carry from bit 23 dropped
// - program counter bit 0 always zero
// - trap or interrupt copies pc and status into the single save pair
// - saved pc upper 8 bits and saved status upper 24 bits read zero
// - accepted nmi copies pc and status into the nmi save pair
// - cause register: nmi code high half, trap/interrupt code low half
// - system registers numbered 0 to 5; 6 to 31 reserved, writes ignored and reads zero
// - status word resets to 20 hex; bits 31 to 8 always zero
// - nmi-in-progress bit set on nmi acceptance and masks further nmi
// - trap-in-progress bit set when a trap is accepted (not when an nmi is taken in the same cycle)
// - interrupt-disable bit blocks maskable interrupt acceptance
// - clamp flag set on saturating overflow, otherwise holds unless software writes the status word
// - carry bit follows carry or borrow of each operation
// - signed-range bit follows signed overflow of each operation
// - negative and zero bits follow each flag-affecting result
// - straps 00 select rom-less, high pin 1 low 0 select single-chip
// - single-chip: port pins, internal entry, bus only via expansion register
// - rom-less: bus pins on, external entry, internal memory unreachable
// - prom modes present a byte-wide eprom-style interface
// - borrow beyond bit 23 in branch calculation also dropped; space wraps
module crms_regs (
  input  wire logic                           i_clk,
  input  wire logic                           i_srst,
  input  wire logic                           i_mode_select_pin_low,
  input  wire logic                           i_mode_select_pin_high,
  input  wire logic                           i_prog_voltage_high,
  input  wire logic                           i_mem_expansion_en,
  input  wire logic [crms_pkg::RIDX_BITS-1:0]  i_rd_addr_a,
  input  wire logic [crms_pkg::RIDX_BITS-1:0]  i_rd_addr_b,
  output logic      [crms_pkg::XLEN-1:0]       o_rd_data_a,
  output logic      [crms_pkg::XLEN-1:0]       o_rd_data_b,
  input  wire logic                           i_gpr_we,
  input  wire logic [crms_pkg::RIDX_BITS-1:0]  i_gpr_waddr,
  input  wire logic [crms_pkg::XLEN-1:0]       i_gpr_wdata,
  input  wire logic                           i_pc_load,
  input  wire logic [crms_pkg::XLEN-1:0]       i_pc_target,
  input  wire logic                           i_pc_add,
  input  wire logic [crms_pkg::XLEN-1:0]       i_pc_offset,
  output logic      [crms_pkg::XLEN-1:0]       o_pc,
  input  wire logic                           i_flag_we,
  input  wire logic                           i_res_carry,
  input  wire logic                           i_res_signed_ovf,
  input  wire logic                           i_res_negative,
  input  wire logic                           i_res_zero,
  input  wire logic                           i_clamp_ovf,
  input  wire logic                           i_sr_we,
  input  wire logic                           i_sr_re,
  input  wire logic [crms_pkg::RIDX_BITS-1:0]  i_sr_num,
  input  wire logic [crms_pkg::XLEN-1:0]       i_sr_wdata,
  output logic      [crms_pkg::XLEN-1:0]       o_sr_rdata,
  input  wire logic                           i_trap_req,
  input  wire logic [crms_pkg::CODE_BITS-1:0]  i_trap_code,
  input  wire logic                           i_irq_req,
  input  wire logic [crms_pkg::CODE_BITS-1:0]  i_irq_code,
  input  wire logic                           i_nmi_req,
  input  wire logic [crms_pkg::CODE_BITS-1:0]  i_nmi_code,
  output logic                                o_trap_taken,
  output logic                                o_irq_taken,
  output logic                                o_nmi_taken,
  output logic      [crms_pkg::XLEN-1:0]       o_status_word,
  output crms_pkg::crms_mode_e                o_mode,
  output logic                                o_bus_ctrl_en,
  output logic                                o_int_rom_en,
  output logic                                o_prom_if_en,
  output logic                                o_exec_en
);
  import crms_pkg::*;

  // ==========================================================================
  // state
  logic [PC_BITS-1:0]   pc_r;
  logic [PC_BITS-1:0]   pc_nxt;
  logic [PC_BITS-1:0]   irq_saved_pc_r;
  logic [STAT_BITS-1:0] irq_saved_status_r;
  logic [PC_BITS-1:0]   nmi_saved_pc_r;
  logic [STAT_BITS-1:0] nmi_saved_status_r;
  logic [XLEN-1:0]      exception_cause_r;
  logic [STAT_BITS-1:0] status_r;
  logic [STAT_BITS-1:0] status_nxt;
  logic                 rst_d_r;
  logic                 sr_valid;
  logic                 sr_wr;
  logic                 any_irq_save;

  // ==========================================================================
  // sub-blocks
  crms_gpr u_gpr (
    .i_clk       (i_clk),
    .i_srst      (i_srst),
    .i_rd_addr_a (i_rd_addr_a),
    .i_rd_addr_b (i_rd_addr_b),
    .o_rd_data_a (o_rd_data_a),
    .o_rd_data_b (o_rd_data_b),
    .i_we        (i_gpr_we),
    .i_waddr     (i_gpr_waddr),
    .i_wdata     (i_gpr_wdata)
  );

  crms_mode_sel u_mode (
    .i_clk                  (i_clk),
    .i_srst                 (i_srst),
    .i_mode_select_pin_low  (i_mode_select_pin_low),
    .i_mode_select_pin_high (i_mode_select_pin_high),
    .i_prog_voltage_high    (i_prog_voltage_high),
    .o_mode                 (o_mode)
  );

  // ==========================================================================
  // mode-derived controls
  always_comb begin
    o_exec_en     = 1'b0;
    o_bus_ctrl_en = 1'b0;
    o_int_rom_en  = 1'b0;
    o_prom_if_en  = 1'b0;
    case (o_mode)
      CRMS_ROMLESS: begin
        o_exec_en     = !i_srst;
        o_bus_ctrl_en = !i_srst;
      end
      CRMS_SINGLE_CHIP: begin
        o_exec_en     = !i_srst;
        o_int_rom_en  = 1'b1;
        o_bus_ctrl_en = !i_srst && i_mem_expansion_en;
      end
      CRMS_PROM_READ, CRMS_PROM_PROGRAM: begin
        o_prom_if_en  = !i_srst;
      end
      default: begin
        o_exec_en     = 1'b0;
      end
    endcase
  end

  // ==========================================================================
  // event acceptance: nmi first, then trap, then maskable interrupt
  always_comb begin
    o_nmi_taken  = o_exec_en && i_nmi_req && !status_r[ST_NMI_IN_PROGRESS];
    o_trap_taken = o_exec_en && i_trap_req && !o_nmi_taken;
    o_irq_taken  = o_exec_en && i_irq_req && !o_nmi_taken && !i_trap_req
                   && !status_r[ST_INTERRUPT_DISABLE];
  end

  assign any_irq_save = o_trap_taken || o_irq_taken;

  // ==========================================================================
  // system register access decode; reserved numbers ignored
  assign sr_valid = i_sr_num <= SR_LAST_DEFINED;
  assign sr_wr    = i_sr_we && sr_valid && o_exec_en;

  // ==========================================================================
  // program counter
  always_comb begin
    pc_nxt = pc_r;
    if (i_pc_load) begin
      pc_nxt = {i_pc_target[PC_BITS-1:1], 1'b0};
    end else if (i_pc_add) begin
      pc_nxt = pc_r + i_pc_offset[PC_BITS-1:0];
      pc_nxt[0] = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    rst_d_r <= i_srst;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pc_r <= '0;
    end else if (rst_d_r) begin
      pc_r <= (o_mode == CRMS_ROMLESS) ? RESET_ENTRY_EXTERNAL
                                       : RESET_ENTRY_INTERNAL;
    end else if (o_exec_en) begin
      pc_r <= pc_nxt;
    end
  end

  assign o_pc = {{(XLEN-PC_BITS){1'b0}}, pc_r};

  // ==========================================================================
  // save registers and cause
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      irq_saved_pc_r     <= '0;
      irq_saved_status_r <= '0;
    end else if (any_irq_save) begin
      irq_saved_pc_r     <= pc_r;
      irq_saved_status_r <= status_r;
    end else if (sr_wr && i_sr_num == SR_IRQ_SAVED_PC) begin
      irq_saved_pc_r     <= i_sr_wdata[PC_BITS-1:0];
    end else if (sr_wr && i_sr_num == SR_IRQ_SAVED_STATUS) begin
      irq_saved_status_r <= i_sr_wdata[STAT_BITS-1:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      nmi_saved_pc_r     <= '0;
      nmi_saved_status_r <= '0;
    end else if (o_nmi_taken) begin
      nmi_saved_pc_r     <= pc_r;
      nmi_saved_status_r <= status_r;
    end else if (sr_wr && i_sr_num == SR_NMI_SAVED_PC) begin
      nmi_saved_pc_r     <= i_sr_wdata[PC_BITS-1:0];
    end else if (sr_wr && i_sr_num == SR_NMI_SAVED_STATUS) begin
      nmi_saved_status_r <= i_sr_wdata[STAT_BITS-1:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      exception_cause_r <= '0;
    end else begin
      if (sr_wr && i_sr_num == SR_EXCEPTION_CAUSE) begin
        exception_cause_r <= i_sr_wdata;
      end
      if (o_nmi_taken) begin
        exception_cause_r[CAUSE_NMI_LSB +: CODE_BITS] <= i_nmi_code;
      end
      if (o_trap_taken) begin
        exception_cause_r[CAUSE_TRP_LSB +: CODE_BITS] <= i_trap_code;
      end else if (o_irq_taken) begin
        exception_cause_r[CAUSE_TRP_LSB +: CODE_BITS] <= i_irq_code;
      end
    end
  end

  // ==========================================================================
  // status word: software write, then flag results, then event bits
  always_comb begin
    status_nxt = status_r;
    if (sr_wr && i_sr_num == SR_STATUS_WORD) begin
      status_nxt = i_sr_wdata[STAT_BITS-1:0];
    end
    if (i_flag_we) begin
      status_nxt[ST_CARRY]            = i_res_carry;
      status_nxt[ST_SIGNED_RANGE_EXC] = i_res_signed_ovf;
      status_nxt[ST_NEGATIVE]         = i_res_negative;
      status_nxt[ST_ZERO]             = i_res_zero;
    end
    if (i_clamp_ovf) begin
      status_nxt[ST_STICKY_CLAMP] = 1'b1;
    end
    if (o_nmi_taken) begin
      status_nxt[ST_NMI_IN_PROGRESS]   = 1'b1;
      status_nxt[ST_INTERRUPT_DISABLE] = 1'b1;
    end
    if (o_trap_taken) begin
      status_nxt[ST_TRAP_IN_PROGRESS]  = 1'b1;
      status_nxt[ST_INTERRUPT_DISABLE] = 1'b1;
    end
    if (o_irq_taken) begin
      status_nxt[ST_INTERRUPT_DISABLE] = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      status_r <= STATUS_RESET;
    end else if (o_exec_en) begin
      status_r <= status_nxt;
    end
  end

  assign o_status_word = {{(XLEN-STAT_BITS){1'b0}}, status_r};

  // ==========================================================================
  // system register read, one cycle after the request
  always_ff @(posedge i_clk) begin
    if (i_srst || !i_sr_re) begin
      o_sr_rdata <= '0;
    end else begin
      case (i_sr_num)
        SR_IRQ_SAVED_PC:     o_sr_rdata <= {{(XLEN-PC_BITS){1'b0}}, irq_saved_pc_r};
        SR_IRQ_SAVED_STATUS: o_sr_rdata <= {{(XLEN-STAT_BITS){1'b0}}, irq_saved_status_r};
        SR_NMI_SAVED_PC:     o_sr_rdata <= {{(XLEN-PC_BITS){1'b0}}, nmi_saved_pc_r};
        SR_NMI_SAVED_STATUS: o_sr_rdata <= {{(XLEN-STAT_BITS){1'b0}}, nmi_saved_status_r};
        SR_EXCEPTION_CAUSE:  o_sr_rdata <= exception_cause_r;
        SR_STATUS_WORD:      o_sr_rdata <= o_status_word;
        default:             o_sr_rdata <= '0;
      endcase
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  sequence s_nmi_accept;
    o_nmi_taken ##0 (pc_r == pc_r);
  endsequence

  sequence s_nmi_saved(logic [PC_BITS-1:0] pc_at);
    nmi_saved_pc_r == pc_at && status_r[ST_NMI_IN_PROGRESS];
  endsequence

  a_pc_upper_zero: assert property (
    o_pc[31:24] == 8'h00 && o_pc[0] == 1'b0)
    else $error("pc upper byte or bit zero not zero");

  a_pc_wrap_add: assert property (
    o_exec_en && i_pc_add && !i_pc_load
    |=> o_pc[23:0] == (($past(o_pc[23:0]) + $past(i_pc_offset[23:0])) & 24'hfffffe))
    else $error("pc add did not wrap within 24 bits");

  a_status_upper_zero: assert property (
    o_status_word[31:8] == 24'h000000)
    else $error("status word reserved bits set");

  a_nmi_save_seq: assert property (
    s_nmi_accept |=> s_nmi_saved($past(pc_r)))
    else $error("nmi save pair not loaded");

  a_nmi_no_nest: assert property (
    status_r[ST_NMI_IN_PROGRESS] |-> !o_nmi_taken)
    else $error("nmi accepted while one in progress");

  a_irq_disabled: assert property (
    status_r[ST_INTERRUPT_DISABLE] |-> !o_irq_taken)
    else $error("interrupt accepted while disabled");

  a_trap_save_pair: assert property (
    o_trap_taken |=> irq_saved_pc_r == $past(pc_r) && irq_saved_status_r == $past(status_r)
                     && status_r[ST_TRAP_IN_PROGRESS])
    else $error("trap save pair or trap bit wrong");

  a_cause_halves: assert property (
    o_nmi_taken && o_irq_taken == 1'b0 |=> exception_cause_r[31:16] == $past(i_nmi_code))
    else $error("nmi cause code not captured");

  a_clamp_sticky: assert property (
    status_r[ST_STICKY_CLAMP] && !(sr_wr && i_sr_num == SR_STATUS_WORD)
    |=> status_r[ST_STICKY_CLAMP])
    else $error("clamp flag dropped");

  a_carry_follows: assert property (
    o_exec_en && i_flag_we |=> status_r[ST_CARRY] == $past(i_res_carry)
                               && status_r[ST_ZERO] == $past(i_res_zero))
    else $error("carry or zero flag did not follow result");

  a_reserved_read_zero: assert property (
    i_sr_re && i_sr_num > SR_LAST_DEFINED |=> o_sr_rdata == 32'h00000000)
    else $error("reserved system register read non-zero");

endmodule

// ### crms_core_model.sv
// crms_core_model: event source of the execution pipeline, plus the strap wiring.
// assumes the bench pulses i_go for one cycle to raise or to cancel a request.
`timescale 1ns/1ps
module crms_core_model (
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  input  wire logic       i_go,
  input  wire logic [1:0] i_kind,
  input  wire logic [1:0] i_straps,
  input  wire logic       i_taken,
  output logic            o_strap_low,
  output logic            o_strap_high,
  output logic [1:0]      o_pend
);
  // ==========================================================================
  // straps follow the bench, which moves them only inside reset;
  // a refused request stays up until taken, cancelled or reset
  assign o_strap_low  = i_straps[0];
  assign o_strap_high = i_straps[1];
  always_ff @(posedge i_clk) begin
    if (i_go) begin
      o_pend <= i_kind;
    end else if (i_srst || i_taken) begin
      o_pend <= 2'h0;
    end
  end
endmodule

// ### crms_regs_tb.sv
// crms_regs_tb: directed bench for the cpu register block.
// assumes crms_pkg, crms_regs and crms_core_model are compiled ahead of it.
`timescale 1ns/1ps
module crms_regs_tb;
  import crms_pkg::*;
  logic        i_clk = 0, i_srst = 1, gwe = 0, pld = 0, pad = 0, fwe = 0, clo = 0, mxe = 0;
  logic        swe = 0, sre = 0, go = 0, got, tk, sl, sh, ttk, itk, ntk, bus, rom, prm, exe;
  logic [1:0]  knd = 0, pd, stp = 2'h2;
  logic [3:0]  fl4 = 0;
  logic [4:0]  ra = 0, wa = 0, sn = 0;
  logic [15:0] cd = 0;
  logic [31:0] wd = 0, pt = 0, po = 0, da, db, pc, srd, st;
  crms_mode_e  md;
  int          n_fail = 0, tests_run = 0;
  assign tk = ttk | itk | ntk;
  // ==========================================================================
  // design and event source
  crms_regs i_crms_regs (
    .i_clk(i_clk), .i_srst(i_srst), .i_mode_select_pin_low(sl), .i_mode_select_pin_high(sh),
    .i_prog_voltage_high(1'b0), .i_mem_expansion_en(mxe), .i_rd_addr_a(ra),
    .i_rd_addr_b(ra), .o_rd_data_a(da), .o_rd_data_b(db), .i_gpr_we(gwe), .i_gpr_waddr(wa),
    .i_gpr_wdata(wd), .i_pc_load(pld), .i_pc_target(pt), .i_pc_add(pad), .i_pc_offset(po),
    .o_pc(pc), .i_flag_we(fwe), .i_res_carry(fl4[3]), .i_res_signed_ovf(fl4[2]),
    .i_res_negative(fl4[1]), .i_res_zero(fl4[0]), .i_clamp_ovf(clo), .i_sr_we(swe),
    .i_sr_re(sre), .i_sr_num(sn), .i_sr_wdata(wd), .o_sr_rdata(srd),
    .i_trap_req(pd == 2'h1), .i_trap_code(cd), .i_irq_req(pd == 2'h2), .i_irq_code(cd),
    .i_nmi_req(pd == 2'h3), .i_nmi_code(cd), .o_trap_taken(ttk), .o_irq_taken(itk),
    .o_nmi_taken(ntk), .o_status_word(st), .o_mode(md), .o_bus_ctrl_en(bus),
    .o_int_rom_en(rom), .o_prom_if_en(prm), .o_exec_en(exe));
  crms_core_model i_crms_core_model (.i_clk(i_clk), .i_srst(i_srst), .i_go(go), .i_straps(stp),
    .i_kind(knd), .i_taken(tk), .o_strap_low(sl), .o_strap_high(sh), .o_pend(pd));
  initial forever #2.5 i_clk = ~i_clk;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // s bits: gwe pld pad fwe clo swe sre go; w picks the value checked after the edge
  task automatic op(input logic [7:0] s, input logic [4:0] n, input logic [31:0] d,
                    input int w, input logic [31:0] e);
    @(posedge i_clk);
    {gwe, pld, pad, fwe, clo, swe, sre, go} <= s;
    {sn, wa, ra} <= {3{n}};
    {wd, pt, po} <= {3{d}};
    {knd, cd, fl4} <= {d[17:0], d[3:0]};
    @(posedge i_clk);
    {gwe, pld, pad, fwe, clo, swe, sre, go} <= 8'h00;
    #1;
    if (w >= 0) chk(w == 0 ? srd : w == 1 ? st : w == 2 ? pc : w == 3 ? da : db, e);
  endtask
  // request held with its code until taken or the window closes, then cancelled
  task automatic ev(input logic [17:0] d, input logic e);
    got = 1'b0;
    op(8'h01, 5'h0, 32'(d), -1, 32'h0);
    for (int i = 0; i < 6 && !got; i++) begin
      got = tk;
      if (!got) op(8'h00, 5'h0, 32'(d), -1, 32'h0);
    end
    chk(got, e);
    op(8'h01, 5'h0, 32'(d[15:0]), -1, 32'h0);
  endtask
  // reset again in mid-run for 6 edges with new straps, which move only inside reset
  task automatic rst(input logic [1:0] p);
    @(posedge i_clk);
    {i_srst, stp} <= {1'b1, p};
    repeat (6) @(posedge i_clk);
    i_srst <= 1'b0;
  endtask
  task automatic summarize();
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge i_clk);
    i_srst <= 1'b0;
    op(8'h00, 5'h0, 32'h0, 1, 32'h20);
    chk(md, CRMS_SINGLE_CHIP);
    chk({bus, rom, prm, exe}, 4'h5);
    op(8'h04, SR_STATUS_WORD, 32'hffff_ff00, 1, 32'h0);
    op(8'h04, 5'h07, 32'hffff_ffff, 1, 32'h0);
    op(8'h02, 5'h07, 32'h0, 0, 32'h0);
    op(8'h40, 5'h0, 32'h12ff_ffff, 2, 32'h00ff_fffe);
    op(8'h20, 5'h0, 32'h4, 2, 32'h2);
    op(8'h20, 5'h0, 32'hffff_fffc, 2, 32'h00ff_fffe);
    $display("done: reset, status, pc");
    ev(18'h2_1234, 1'b1);
    op(8'h02, SR_IRQ_SAVED_PC, 32'h0, 0, 32'h00ff_fffe);
    op(8'h02, SR_EXCEPTION_CAUSE, 32'h0, 0, 32'h1234);
    ev(18'h2_1234, 1'b0);
    ev(18'h1_0040, 1'b1);
    op(8'h02, SR_IRQ_SAVED_STATUS, 32'h0, 1, 32'h60);
    chk(srd, 32'h20);
    ev(18'h3_0010, 1'b1);
    op(8'h02, SR_NMI_SAVED_STATUS, 32'h0, 1, 32'he0);
    chk(srd, 32'h60);
    op(8'h02, SR_EXCEPTION_CAUSE, 32'h0, 0, 32'h0010_0040);
    ev(18'h3_0010, 1'b0);
    op(8'h04, SR_NMI_SAVED_PC, 32'hffff_ffff, -1, 32'h0);
    op(8'h02, SR_NMI_SAVED_PC, 32'h0, 0, 32'h00ff_ffff);
    $display("done: events");
    op(8'h10, 5'h0, 32'ha, 1, 32'hea);
    op(8'h08, 5'h0, 32'h0, 1, 32'hfa);
    op(8'h10, 5'h0, 32'h5, 1, 32'hf5);
    op(8'h80, 5'h0, 32'hffff_ffff, -1, 32'h0);
    op(8'h00, 5'h0, 32'h0, 3, 32'h0);
    op(8'h80, 5'h1f, 32'ha5a5_5a5a, -1, 32'h0);
    op(8'h00, 5'h1f, 32'h0, 4, 32'ha5a5_5a5a);
    $display("done: flags, general registers");
    @(posedge i_clk);
    mxe <= 1'b1;
    op(8'h00, 5'h0, 32'h0, -1, 32'h0);
    chk({bus, rom, prm, exe}, 4'hd);
    rst(2'h0);
    op(8'h00, 5'h0, 32'h0, 2, 32'(RESET_ENTRY_EXTERNAL));
    chk(md, CRMS_ROMLESS);
    chk({bus, rom, prm, exe}, 4'h9);
    rst(2'h3);
    op(8'h00, 5'h0, 32'h0, 1, 32'(STATUS_RESET));
    chk(md, CRMS_PROM_READ);
    chk({bus, rom, prm, exe}, 4'h2);
    $display("done: modes");
    summarize();
  end
endmodule
